/* File: flash_block_protection.v */
// Overview of operation
// R1: separate level per 2 kB block, readable
// R2: level is full, read-only or fetch-only
// R3: full access allows read, fetch, erase, program
// R4: read-only blocks erase and program
// R5: fetch-only rejects data reads, core and debugger
// R6: tightening changes are accepted
// R7: fetch-only level never changes again
// R8: loosening is blocked and reported failed
// R9: uncommitted levels last only until reset
// R10: violations signalled even when uncommitted
// R11: protection commit stores levels permanently
// R12: clocks per microsecond stored and readable
// R13: count times programming, not reads
// R14: two user words, read/write with result
// R15: user commit stores user words permanently
// R16: programming ANDs new data into old
// R17: erase fills ones; protected blocks refused
// R18: invalid access raises violation event
// R19: program or erase completion raises event
// R20: reset loads stored levels before accesses
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "flash_block_protection_defines.vh"

module flash_block_protection #(
    parameter BLK_BITS = 2,
    parameter USEC_W = 8,
    parameter PROG_TIME_US = 1
) (
    input wire clk_sys,
    input wire resetn,
    input wire nvm_erase_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire acc_valid,
    input wire [1:0] acc_kind,
    input wire acc_debug,
    input wire [BLK_BITS+10:0] acc_addr,
    input wire [31:0] acc_wdata,
    output reg acc_done,
    output reg acc_ok,
    output reg [31:0] acc_rdata,
    output reg access_violation,
    output reg op_complete
);

localparam NB = 1 << BLK_BITS;
localparam AW = BLK_BITS + 11;
localparam WB = `WORDS_PER_BLOCK_BITS;
localparam MW = BLK_BITS + WB;
localparam ST_LOAD = 2'd0;
localparam ST_IDLE = 2'd1;
localparam ST_ERASE = 2'd2;
localparam ST_PROG = 2'd3;

// register index returned by the address decoder
localparam RI_NONE = 3'd0;
localparam RI_PADDR = 3'd1;
localparam RI_PLVL = 3'd2;
localparam RI_STAT = 3'd3;
localparam RI_CMD = 3'd4;
localparam RI_USEC = 3'd5;
localparam RI_USER0 = 3'd6;
localparam RI_USER1 = 3'd7;

function [2:0] reg_index;
    input [11:0] a;
    begin
        if (a == `OFS_PROT_ADDR)
            reg_index = RI_PADDR;
        else if (a == `OFS_PROT_LEVEL)
            reg_index = RI_PLVL;
        else if (a == `OFS_STATUS)
            reg_index = RI_STAT;
        else if (a == `OFS_COMMAND)
            reg_index = RI_CMD;
        else if (a == `OFS_USEC)
            reg_index = RI_USEC;
        else if (a == `OFS_USER0)
            reg_index = RI_USER0;
        else if (a == `OFS_USER1)
            reg_index = RI_USER1;
        else
            reg_index = RI_NONE;
    end
endfunction

// a change is legal only toward an equal or stricter, valid level
function change_ok;
    input [1:0] cur;
    input [1:0] req;
    begin
        change_ok = (req != 2'b11) && (req >= cur) &&
            ((cur != `LEVEL_FETCH_ONLY) || (req == cur)); // R6 R7 R8
    end
endfunction

reg [31:0] mem [0:(1<<MW)-1];
reg [1:0] lvl_act_reg [0:NB-1];
reg [1:0] lvl_nv_reg [0:NB-1];
reg [31:0] user0_reg;
reg [31:0] user1_reg;
reg [31:0] user0_nv_reg;
reg [31:0] user1_nv_reg;
reg user_locked_reg;
reg prot_saved_reg;
reg [USEC_W-1:0] usec_reg;
reg [AW-1:0] prot_addr_reg;
reg fail_reg;
reg [1:0] state_reg;
reg [MW-1:0] word_reg;
reg [31:0] wdata_reg;
reg [WB-1:0] erase_cnt_reg;
reg [USEC_W+15:0] prog_cnt_reg;

wire [2:0] ri = reg_index(paddr);
wire apb_acc = psel & penable;
wire apb_wr = apb_acc & pready & pwrite;
wire [BLK_BITS-1:0] sel_blk = prot_addr_reg[AW-1:`BLOCK_SHIFT];
wire [BLK_BITS-1:0] acc_blk = acc_addr[AW-1:`BLOCK_SHIFT];
wire [1:0] acc_lvl = lvl_act_reg[acc_blk];
wire [1:0] sel_lvl = lvl_act_reg[sel_blk];
wire lvl_wr = apb_wr && (ri == RI_PLVL);
wire lvl_wr_ok = lvl_wr && change_ok(sel_lvl, pwdata[1:0]);
wire cmd_wr = apb_wr && (ri == RI_CMD);
wire prot_save = cmd_wr && pwdata[`CMD_PROT_SAVE];
wire user_save = cmd_wr && pwdata[`CMD_USER_SAVE];
wire user_wr = apb_wr && ((ri == RI_USER0) || (ri == RI_USER1));
wire take = (state_reg == ST_IDLE) && acc_valid && !acc_done;
wire is_mod = (acc_kind == `KIND_PROGRAM) || (acc_kind == `KIND_ERASE);
// only full access allows erase/program; fetch-only also bars reads
wire acc_allowed = is_mod ? (acc_lvl == `LEVEL_FULL_ACCESS) : // R3 R4 R17
    (acc_kind == `KIND_FETCH) || (acc_lvl != `LEVEL_FETCH_ONLY); // R5
// programming time; a zero count still takes one cycle
wire [USEC_W+15:0] prog_cycles =
    usec_reg * PROG_TIME_US[15:0]; // R13

// per-block active and committed levels
genvar g;
generate
    for (g = 0; g < NB; g = g + 1)
    begin : blk
        // reset lands on the strictest level so nothing leaks before load
        always @(posedge clk_sys or negedge resetn)
        begin
            if (!resetn)
                lvl_act_reg[g] <= `LEVEL_FETCH_ONLY;
            else if (state_reg == ST_LOAD)
                lvl_act_reg[g] <= lvl_nv_reg[g]; // R9 R20
            else if (lvl_wr_ok && (sel_blk == g))
                lvl_act_reg[g] <= pwdata[1:0]; // R6
        end

        // committed storage survives resetn; only a factory wipe clears it
        always @(posedge clk_sys or negedge nvm_erase_n)
        begin
            if (!nvm_erase_n)
                lvl_nv_reg[g] <= `LEVEL_FULL_ACCESS;
            else if (prot_save && (state_reg != ST_LOAD))
                lvl_nv_reg[g] <= lvl_act_reg[g]; // R11
        end
    end
endgenerate

always @(posedge clk_sys or negedge nvm_erase_n)
begin
    if (!nvm_erase_n)
    begin
        user0_nv_reg <= `USER_RESET;
        user1_nv_reg <= `USER_RESET;
        user_locked_reg <= 1'b0;
        prot_saved_reg <= 1'b0;
    end
    else
    begin
        if (user_save && !user_locked_reg)
        begin
            user0_nv_reg <= user0_reg; // R15
            user1_nv_reg <= user1_reg;
            user_locked_reg <= 1'b1;
        end
        if (prot_save && (state_reg != ST_LOAD))
            prot_saved_reg <= 1'b1; // R11
    end
end

// software registers
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        user0_reg <= `USER_RESET;
        user1_reg <= `USER_RESET;
        usec_reg <= `USEC_RESET;
        prot_addr_reg <= {AW{1'b0}};
        fail_reg <= 1'b0;
    end
    else if (state_reg == ST_LOAD)
    begin
        user0_reg <= user0_nv_reg; // R20
        user1_reg <= user1_nv_reg;
    end
    else
    begin
        if (apb_wr && (ri == RI_PADDR))
            prot_addr_reg <= pwdata[AW-1:0]; // R1
        if (apb_wr && (ri == RI_USEC))
            usec_reg <= pwdata[USEC_W-1:0]; // R12
        if (user_wr && !user_locked_reg)
        begin
            if (ri == RI_USER0)
                user0_reg <= pwdata; // R14
            else
                user1_reg <= pwdata;
        end
        // committed user words can no longer be rewritten
        if (user_wr)
            fail_reg <= user_locked_reg; // R14
        else if (lvl_wr)
            fail_reg <= !lvl_wr_ok; // R8
        else if (cmd_wr)
            fail_reg <= user_save && user_locked_reg; // R15
    end
end

// apb slave: one wait state, registered answer
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        pready <= 1'b0;
        prdata <= `ZERO_WORD;
        pslverr <= 1'b0;
    end
    else
    begin
        pready <= apb_acc & ~pready;
        if (apb_acc & ~pready)
        begin
            pslverr <= (ri == RI_NONE);
            prdata <= `ZERO_WORD;
            if (!pwrite)
            begin
                if (ri == RI_PADDR)
                    prdata[AW-1:0] <= prot_addr_reg;
                else if (ri == RI_PLVL)
                    prdata[1:0] <= sel_lvl; // R1 R2
                else if (ri == RI_STAT)
                    prdata[3:0] <= {user_locked_reg, prot_saved_reg,
                        state_reg != ST_IDLE, fail_reg};
                else if (ri == RI_USEC)
                    prdata[USEC_W-1:0] <= usec_reg; // R12
                else if (ri == RI_USER0)
                    prdata <= user0_reg; // R14
                else if (ri == RI_USER1)
                    prdata <= user1_reg;
            end
        end
        else
        begin
            pslverr <= 1'b0;
        end
    end
end

// flash access sequencer
always @(posedge clk_sys or negedge resetn)
begin
    if (!resetn)
    begin
        state_reg <= ST_LOAD;
        word_reg <= {MW{1'b0}};
        wdata_reg <= `ZERO_WORD;
        erase_cnt_reg <= {WB{1'b0}};
        prog_cnt_reg <= {(USEC_W+16){1'b0}};
        acc_done <= 1'b0;
        acc_ok <= 1'b0;
        acc_rdata <= `ZERO_WORD;
        access_violation <= 1'b0;
        op_complete <= 1'b0;
    end
    else
    begin
        acc_done <= 1'b0;
        access_violation <= 1'b0;
        op_complete <= 1'b0;
        case (state_reg)
            ST_LOAD:
            begin
                state_reg <= ST_IDLE; // R20
            end
            ST_IDLE:
            begin
                if (take)
                begin
                    word_reg <= acc_addr[AW-1:2];
                    wdata_reg <= acc_wdata;
                    erase_cnt_reg <= {WB{1'b0}};
                    prog_cnt_reg <= prog_cycles;
                    if (!acc_allowed)
                    begin
                        acc_done <= 1'b1;
                        acc_ok <= 1'b0;
                        acc_rdata <= `ZERO_WORD;
                        access_violation <= 1'b1; // R10 R18
                    end
                    else if (acc_kind == `KIND_ERASE)
                        state_reg <= ST_ERASE;
                    else if (acc_kind == `KIND_PROGRAM)
                        state_reg <= ST_PROG;
                    else
                    begin
                        acc_done <= 1'b1;
                        acc_ok <= 1'b1;
                        acc_rdata <= mem[acc_addr[AW-1:2]]; // R13
                    end
                end
            end
            ST_ERASE:
            begin
                erase_cnt_reg <= erase_cnt_reg + 1'b1;
                if (&erase_cnt_reg)
                begin
                    state_reg <= ST_IDLE;
                    acc_done <= 1'b1;
                    acc_ok <= 1'b1;
                    acc_rdata <= `ZERO_WORD;
                    op_complete <= 1'b1; // R19
                end
            end
            default:
            begin
                if (prog_cnt_reg > 1)
                    prog_cnt_reg <= prog_cnt_reg - 1'b1; // R13
                else
                begin
                    state_reg <= ST_IDLE;
                    acc_done <= 1'b1;
                    acc_ok <= 1'b1;
                    acc_rdata <= `ZERO_WORD;
                    op_complete <= 1'b1; // R19
                end
            end
        endcase
    end
end

// flash array; contents are unknown until erased
always @(posedge clk_sys)
begin
    if (state_reg == ST_ERASE)
        mem[{word_reg[MW-1:WB], erase_cnt_reg}] <= `ERASED_WORD; // R17
    else if ((state_reg == ST_PROG) && (prog_cnt_reg <= 1))
        mem[word_reg] <= mem[word_reg] & wdata_reg; // R16
end

endmodule
`default_nettype wire

/* File: flash_block_protection_defines.vh */
`ifndef FLASH_BLOCK_PROTECTION_DEFINES_VH
`define FLASH_BLOCK_PROTECTION_DEFINES_VH

// register byte offsets
`define OFS_PROT_ADDR 12'h000
`define OFS_PROT_LEVEL 12'h004
`define OFS_STATUS 12'h008
`define OFS_COMMAND 12'h00C
`define OFS_USEC 12'h010
`define OFS_USER0 12'h014
`define OFS_USER1 12'h018

// protection levels, ordered by strictness
`define LEVEL_FULL_ACCESS 2'b00
`define LEVEL_READ_ONLY 2'b01
`define LEVEL_FETCH_ONLY 2'b10

// access kinds on the flash port
`define KIND_FETCH 2'b00
`define KIND_READ 2'b01
`define KIND_PROGRAM 2'b10
`define KIND_ERASE 2'b11

// status and command bits
`define STAT_FAIL 0
`define STAT_BUSY 1
`define STAT_PROT_SAVED 2
`define STAT_USER_LOCKED 3
`define CMD_PROT_SAVE 0
`define CMD_USER_SAVE 1

// geometry: 2 kB block, byte address bits inside a block
`define BLOCK_SHIFT 11
`define WORDS_PER_BLOCK_BITS 9

// reset and erased values
`define ERASED_WORD 32'hFFFF_FFFF
`define USER_RESET 32'hFFFF_FFFF
`define USEC_RESET 8'h28
`define ZERO_WORD 32'h0000_0000

`endif

/* File: flash_block_protection_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_block_protection_monitor (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic acc_valid,
    input wire logic [1:0] acc_kind,
    input wire logic acc_done,
    input wire logic acc_ok,
    input wire logic [31:0] acc_rdata,
    input wire logic access_violation,
    input wire logic op_complete
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    property p_wait_one;
        psel && $rose(penable) |=> pready;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("late pready");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("long pready");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("lone pslverr");
    property p_viol_done;
        access_violation |-> acc_done && !acc_ok;
    endproperty
    a_viol_done: assert property (p_viol_done) else $error("bad violation");
    property p_refuse;
        acc_done && !acc_ok |-> access_violation && acc_rdata == 32'h0;
    endproperty
    a_refuse: assert property (p_refuse) else $error("silent refusal");
    property p_complete;
        op_complete |-> acc_done && acc_ok && acc_kind[1];
    endproperty
    a_complete: assert property (p_complete) else $error("bad complete");
    // every finished program or erase must also raise the event pulse
    property p_op_event;
        acc_done && acc_ok && acc_kind[1] |-> op_complete;
    endproperty
    a_op_event: assert property (p_op_event) else $error("no complete");
    property p_fetch;
        $rose(acc_valid) && acc_kind == 2'h0 |-> ##[1:3] acc_done && acc_ok;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch refused");
    // accepted program and erase are timed, never answered at once
    property p_op_time;
        op_complete |-> $past(acc_valid, 8);
    endproperty
    a_op_time: assert property (p_op_time) else $error("op too fast");
endmodule
`default_nettype wire

/* File: flash_requester.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_requester (
    input wire logic clk_sys,
    input wire logic acc_done,
    input wire logic acc_ok,
    input wire logic [31:0] acc_rdata,
    output logic acc_valid,
    output logic [1:0] acc_kind,
    output logic acc_debug,
    output logic [12:0] acc_addr,
    output logic [31:0] acc_wdata
);
    initial
    begin
        acc_valid = 1'b0;
        acc_kind = 2'h0;
        acc_debug = 1'b0;
        acc_addr = 13'h0;
        acc_wdata = 32'h0;
    end
    task automatic access(input logic [1:0] k, input logic d,
        input logic [12:0] a, input logic [31:0] w,
        output logic ok, output logic [31:0] q);
        @(posedge clk_sys);
        acc_valid <= 1'b1;
        acc_kind <= k;
        acc_debug <= d;
        acc_addr <= a;
        acc_wdata <= w;
        @(posedge clk_sys);
        while (acc_done !== 1'b1)
            @(posedge clk_sys);
        ok = acc_ok;
        q = acc_rdata;
        acc_valid <= 1'b0;
        // released address and write data go inverted so a stale value never passes
        acc_addr <= ~a;
        acc_wdata <= ~w;
    endtask
endmodule
`default_nettype wire

/* File: flash_block_protection_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_block_protection_defines.vh"
module flash_block_protection_tb_top;
    logic clk_sys, resetn, nvm_erase_n, psel, penable, pwrite, dbg, e, ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, acc_rdata, acc_wdata, q;
    logic pready, pslverr, acc_valid, acc_debug, acc_done, acc_ok;
    logic access_violation, op_complete;
    logic [1:0] acc_kind;
    logic [12:0] acc_addr;
    int err_count, checks_done, cycles;
    flash_block_protection dut (.clk_sys(clk_sys), .resetn(resetn),
        .nvm_erase_n(nvm_erase_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .acc_valid(acc_valid),
        .acc_kind(acc_kind), .acc_debug(acc_debug), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_done(acc_done), .acc_ok(acc_ok),
        .acc_rdata(acc_rdata), .access_violation(access_violation),
        .op_complete(op_complete));
    flash_requester cpu (.clk_sys(clk_sys), .acc_done(acc_done),
        .acc_ok(acc_ok), .acc_rdata(acc_rdata), .acc_valid(acc_valid),
        .acc_kind(acc_kind), .acc_debug(acc_debug), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata));
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    // waits until the busy bit clears before judging the status word
    task automatic sts(input logic [31:0] x);
        do apb(1'b0, `OFS_STATUS, 32'h0); while (q[1] !== 1'b0);
        chk(q, x);
    endtask
    task automatic lvl(input logic [1:0] v);
        apb(1'b1, `OFS_PROT_ADDR, 32'h0);
        apb(1'b1, `OFS_PROT_LEVEL, {30'h0, v});
    endtask
    task automatic acc(input logic [1:0] k, input logic [12:0] a,
        input logic [31:0] w, input logic x, input logic [31:0] y);
        cpu.access(k, dbg, a, w, ok, q);
        chk({31'h0, ok}, {31'h0, x});
        chk(q, y);
    endtask
    task automatic rst;
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            results;
        end
    end
    initial
    begin
        {resetn, nvm_erase_n, psel, penable, pwrite, dbg} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        nvm_erase_n <= 1'b1;
        rd(`OFS_USEC, 32'h0000_0028);
        apb(1'b1, `OFS_USEC, 32'h0000_000A);
        rd(`OFS_USEC, 32'h0000_000A);
        apb(1'b1, `OFS_USER0, 32'h1234_5678);
        apb(1'b1, `OFS_USER1, 32'h8765_4321);
        rd(`OFS_USER0, 32'h1234_5678);
        rd(`OFS_USER1, 32'h8765_4321);
        rd(12'h01C, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("register test done");
        acc(`KIND_ERASE, 13'h0, 32'h0, 1'b1, 32'h0);
        acc(`KIND_READ, 13'h07FC, 32'h0, 1'b1, `ERASED_WORD);
        acc(`KIND_PROGRAM, 13'h4, 32'hA5A5_0F0F, 1'b1, 32'h0);
        acc(`KIND_PROGRAM, 13'h4, 32'h0F0F_FFFF, 1'b1, 32'h0);
        acc(`KIND_READ, 13'h4, 32'h0, 1'b1, 32'h0505_0F0F);
        lvl(`LEVEL_READ_ONLY);
        sts(32'h0);
        lvl(`LEVEL_FULL_ACCESS);
        sts(32'h1);
        rd(`OFS_PROT_LEVEL, 32'h1);
        acc(`KIND_ERASE, 13'h0, 32'h0, 1'b0, 32'h0);
        acc(`KIND_PROGRAM, 13'h8, 32'h0, 1'b0, 32'h0);
        acc(`KIND_FETCH, 13'h4, 32'h0, 1'b1, 32'h0505_0F0F);
        lvl(`LEVEL_FETCH_ONLY);
        rd(`OFS_PROT_LEVEL, 32'h2);
        acc(`KIND_READ, 13'h4, 32'h0, 1'b0, 32'h0);
        dbg = 1'b1;
        acc(`KIND_READ, 13'h4, 32'h0, 1'b0, 32'h0);
        dbg = 1'b0;
        acc(`KIND_FETCH, 13'h4, 32'h0, 1'b1, 32'h0505_0F0F);
        lvl(`LEVEL_READ_ONLY);
        sts(32'h1);
        rd(`OFS_PROT_LEVEL, 32'h2);
        apb(1'b1, `OFS_PROT_ADDR, 32'h0000_0800);
        rd(`OFS_PROT_LEVEL, 32'h0);
        $display("access test done");
        rst;
        apb(1'b1, `OFS_PROT_ADDR, 32'h0);
        rd(`OFS_PROT_LEVEL, 32'h0);
        rd(`OFS_USER0, `USER_RESET);
        lvl(`LEVEL_READ_ONLY);
        apb(1'b1, `OFS_COMMAND, 32'h1);
        sts(32'h4);
        apb(1'b1, `OFS_USER0, 32'hCAFE_0001);
        apb(1'b1, `OFS_COMMAND, 32'h2);
        sts(32'hC);
        apb(1'b1, `OFS_USER0, 32'h0);
        sts(32'hD);
        rd(`OFS_USER0, 32'hCAFE_0001);
        rst;
        rd(`OFS_PROT_LEVEL, 32'h1);
        rd(`OFS_USER0, 32'hCAFE_0001);
        $display("commit test done");
        results;
    end
endmodule
bind flash_block_protection flash_block_protection_monitor mon (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .acc_valid(acc_valid),
    .acc_kind(acc_kind), .acc_done(acc_done), .acc_ok(acc_ok),
    .acc_rdata(acc_rdata), .access_violation(access_violation),
    .op_complete(op_complete));
`default_nettype wire
